// ---- rtl/pin_nine_pkg.sv ----
// Constants for the pin nine control block: register map, fields, resets, timing.
// Assumes a 250 MHz core clock and a 32-bit APB register bus.
package pin_nine_pkg;
    // Byte addresses of the registers
    localparam logic [15:0] CTRL_ADDR = 16'h4040;
    localparam logic [15:0] IRQ_STATUS_ADDR = 16'h4100;
    localparam logic [15:0] IRQ_CLEAR_ADDR = 16'h4104;
    localparam logic [15:0] IRQ_ENABLE_ADDR = 16'h4108;
    localparam logic [15:0] OUT_LEVEL_ADDR = 16'h410c;
    localparam logic [15:0] PIN_STATE_ADDR = 16'h4110;

    // Control register field positions
    localparam int DIR_BIT = 15;
    localparam int PULL_HI = 14;
    localparam int PULL_LO = 13;
    localparam int EDGE_MODE_BIT = 12;
    localparam int DOMAIN_BIT = 11;
    localparam int POL_BIT = 10;
    localparam int OD_BIT = 9;
    localparam int ENABLE_BIT = 7;
    localparam int FN_HI = 3;
    localparam int FN_LO = 0;

    // Control reset: input, pull-down, non-inverted, disabled, function 0
    localparam logic [15:0] CTRL_RESET = 16'ha400;
    // Bits that hold state; 8 and 6:4 stay zero
    localparam logic [15:0] CTRL_MASK = 16'hfe8f;

    // Pull field codes
    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP = 2'h2;
    localparam logic [1:0] PULL_BAD = 2'h3;

    // Input function codes with long debounce
    localparam logic [3:0] FN_IN_GPIO_SLOW = 4'h0;
    localparam logic [3:0] FN_IN_SLEEP_SLOW = 4'h4;
    localparam logic [3:0] FN_IN_CTRL1_SLOW = 4'he;
    localparam logic [3:0] FN_IN_CTRL2_SLOW = 4'hf;

    // Interrupt and state bits
    localparam int EDGE_EVENT_BIT = 0;
    localparam int OUT_LEVEL_BIT = 0;
    localparam int STATE_LEVEL_BIT = 0;
    localparam int STATE_RAW_BIT = 1;

    // Long debounce window
    localparam int CLK_MHZ = 250;
    localparam int DEBOUNCE_LONG_US = 100;
    localparam int DEBOUNCE_LONG_CYCLES = DEBOUNCE_LONG_US * CLK_MHZ;
    localparam int DEBOUNCE_CNT_W = 16;
endpackage

// ---- rtl/pin_debounce.sv ----
// Debounce filter for one level: bypass or long window.
// Assumes the input is already synchronous to the core clock.
`timescale 1ns/10ps
module pin_debounce #(
    parameter int CYCLES = pin_nine_pkg::DEBOUNCE_LONG_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic level_in,
    input wire logic long_en,
    output logic level_out
);
    logic stable_q;
    logic stable_d;
    logic [pin_nine_pkg::DEBOUNCE_CNT_W-1:0] cnt_q;
    logic [pin_nine_pkg::DEBOUNCE_CNT_W-1:0] cnt_d;
    logic differs;
    logic done;

    // A change must persist for the whole window before it is passed on
    assign differs = level_in != stable_q;
    assign done = cnt_q == (pin_nine_pkg::DEBOUNCE_CNT_W)'(CYCLES - 1);
    assign cnt_d = (!long_en || !differs || done) ? '0 : cnt_q + 1'b1;
    assign stable_d = (!long_en || (differs && done)) ? level_in : stable_q;
    assign level_out = stable_q;

    // Filter state
    always_ff @(posedge clk) begin
        if (srst) begin
            stable_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            stable_q <= stable_d;
            cnt_q <= cnt_d;
        end
    end
endmodule

// ---- rtl/pin_nine_ctrl.sv ----
// Control and function routing for general-purpose pin nine.
// Holds the control word, a one-bit interrupt block and both pin directions.
// Assumes APB on the core clock and pin inputs synchronous to it.
// Assumes the pad, its pull resistors and every function source sit outside.
// Clock functions are routed as plain levels, so they carry one cycle of lag.
//
// Summary of operation
// - Direction bit 15 resets to input; function 0 debounced, 1 plain input.
// - Input codes 2-6: power on/off, sleep/wake, slow sleep/wake, sleep, power-on.
// - Input code 7 watchdog reset; 8 and 9 voltage-scaling selects.
// - Input 10-11 hardware enables, 12-13 controls, 14-15 debounced controls.
// - Output 0 register level, 1 slow clock, 2-3 states, 4 state change.
// - Output 10-11 power enables, 12-13 supply goods, 14 clock, 15 aux reset.
// - Pull field resets to pull-down; code 11 reserved, never written.
// - Edge mode 0 fires on active edge; mode 1 on both edges.
// - Polarity bit resets non-inverted; zero treats the pin as active low.
// - Output-type bit selects push-pull or open drain.
// - Enable bit resets to zero, holding the pin tri-stated.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
module pin_nine_ctrl #(
    parameter int DEBOUNCE_CYCLES = pin_nine_pkg::DEBOUNCE_LONG_CYCLES
) (
    input wire logic CORE_CLK,
    input wire logic SRST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ,
    // Pin
    input wire logic PIN_IN,
    output logic PIN_OUT,
    output logic PIN_OE_N,
    output logic PULL_UP_EN,
    output logic PULL_DOWN_EN,
    // Input functions
    output logic PWR_ONOFF_REQ,
    output logic SLEEP_WAKE_REQ,
    output logic SLEEP_REQ,
    output logic PWR_ON_REQ,
    output logic WDOG_RESET_IN,
    output logic VOLTAGE_SCALE_SELECT_ONE,
    output logic VOLTAGE_SCALE_SELECT_TWO,
    output logic HW_ENABLE_ONE,
    output logic HW_ENABLE_TWO,
    output logic HW_CONTROL_ONE,
    output logic HW_CONTROL_TWO,
    // Output function sources
    input wire logic SLOW_OSC_CLK,
    input wire logic ON_STATE,
    input wire logic SLEEP_STATE,
    input wire logic PWR_STATE_CHANGE,
    input wire logic SCALE_ONE_DONE,
    input wire logic SCALE_TWO_DONE,
    input wire logic EXT_PWR_EN_ONE,
    input wire logic EXT_PWR_EN_TWO,
    input wire logic SYSTEM_SUPPLY_OK,
    input wire logic CONVERTER_POWER_OK,
    input wire logic EXT_PWR_CLK,
    input wire logic AUX_RESET
);
    // One-hot decode of a 4-bit function code
    // Shared by input routing and output source select so both agree on codes
    function automatic logic [15:0] fn_onehot(input logic [3:0] code);
        fn_onehot = 16'h0001 << code;
    endfunction

    // Stored state; everything else is decode around it
    logic [15:0] ctrl_q;
    logic [15:0] ctrl_d;
    logic irq_status_q;
    logic irq_status_d;
    logic irq_enable_q;
    logic out_level_q;
    logic [31:0] prdata_q;
    logic [31:0] rdata;
    logic pin_q;
    logic level_q;
    logic [15:0] in_func_q;
    logic pin_out_q;
    logic pin_oe_n_q;

    // Register fields
    // Bit 11 selects the supply domain; it is stored and read back only
    wire pin_direction = ctrl_q[pin_nine_pkg::DIR_BIT];
    wire [1:0] pull_select = ctrl_q[pin_nine_pkg::PULL_HI:pin_nine_pkg::PULL_LO];
    wire irq_edge_mode = ctrl_q[pin_nine_pkg::EDGE_MODE_BIT];
    wire pin_polarity = ctrl_q[pin_nine_pkg::POL_BIT];
    wire open_drain_select = ctrl_q[pin_nine_pkg::OD_BIT];
    wire pin_enable = ctrl_q[pin_nine_pkg::ENABLE_BIT];
    wire [3:0] pin_function_select = ctrl_q[pin_nine_pkg::FN_HI:pin_nine_pkg::FN_LO];

    // APB decode; the slave never inserts wait states
    // A non-zero upper address half is treated as unmapped, not aliased
    wire setup = PSEL && !PENABLE;
    wire access = PSEL && PENABLE;
    wire [15:0] addr = PADDR[15:0];
    wire upper_zero = PADDR[31:16] == 16'h0000;
    wire hit_ctrl = upper_zero && addr == pin_nine_pkg::CTRL_ADDR;
    wire hit_status = upper_zero && addr == pin_nine_pkg::IRQ_STATUS_ADDR;
    wire hit_clear = upper_zero && addr == pin_nine_pkg::IRQ_CLEAR_ADDR;
    wire hit_enable = upper_zero && addr == pin_nine_pkg::IRQ_ENABLE_ADDR;
    wire hit_level = upper_zero && addr == pin_nine_pkg::OUT_LEVEL_ADDR;
    wire hit_state = upper_zero && addr == pin_nine_pkg::PIN_STATE_ADDR;
    wire hit_any = hit_ctrl | hit_status | hit_clear | hit_enable | hit_level | hit_state;
    wire wr = access && PWRITE && hit_any;
    wire wr_ctrl = wr && hit_ctrl;
    wire wr_clear = wr && hit_clear;
    wire wr_enable = wr && hit_enable;
    wire wr_level = wr && hit_level;

    // Zero wait states: every access completes at its first access edge
    assign PREADY = 1'b1;
    // Unmapped addresses answer with an error and read zero
    assign PSLVERR = access && !hit_any;
    assign PRDATA = prdata_q;

    // Write data conditioning for the control word
    // unassigned bits masked
    wire [15:0] wdata_masked = PWDATA[15:0] & pin_nine_pkg::CTRL_MASK;
    wire pull_bad = wdata_masked[pin_nine_pkg::PULL_HI:pin_nine_pkg::PULL_LO]
        == pin_nine_pkg::PULL_BAD;
    wire [1:0] pull_keep = pull_bad ? pull_select
        : wdata_masked[pin_nine_pkg::PULL_HI:pin_nine_pkg::PULL_LO];
    assign ctrl_d = {wdata_masked[15], pull_keep, wdata_masked[12:0]};

    // Read mux; the clear register is write-only and reads zero
    // Pin state reads the raw sample above the conditioned level
    assign rdata = hit_ctrl ? {16'h0000, ctrl_q}
        : hit_status ? {31'h0, irq_status_q}
        : hit_enable ? {31'h0, irq_enable_q}
        : hit_level ? {31'h0, out_level_q}
        : hit_state ? {30'h0, pin_q, level_q}
        : 32'h0000_0000;

    // Read data is captured in the setup cycle so PRDATA comes from a flop
    // Trade-off: a read returns the state one cycle before its access edge
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup) begin
            prdata_q <= PWRITE ? 32'h0000_0000 : rdata;
        end
    end

    // A write lands at the access edge; the pin follows one edge later
    // register resets
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            ctrl_q <= pin_nine_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= ctrl_d;
        end
    end

    // Software-owned level and interrupt enable
    // Only bit 0 of each word is kept; other data bits are dropped
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            out_level_q <= 1'b0;
            irq_enable_q <= 1'b0;
        end else begin
            if (wr_level) begin
                out_level_q <= PWDATA[pin_nine_pkg::OUT_LEVEL_BIT];
            end
            if (wr_enable) begin
                irq_enable_q <= PWDATA[pin_nine_pkg::EDGE_EVENT_BIT];
            end
        end
    end

    // Input conditioning: sample, then polarity, then optional long filter
    // The function outputs and the interrupt share this one conditioned level
    wire in_active = pin_enable && pin_direction;

    // Polarity goes before the filter, so the filter always sees active high
    // inverted sense
    wire pol_level = pin_q ^ ~pin_polarity;
    // Filter width is a parameter so a bench can shorten it
    // long debounce codes
    wire long_fn = pin_function_select == pin_nine_pkg::FN_IN_GPIO_SLOW
        || pin_function_select == pin_nine_pkg::FN_IN_SLEEP_SLOW
        || pin_function_select == pin_nine_pkg::FN_IN_CTRL1_SLOW
        || pin_function_select == pin_nine_pkg::FN_IN_CTRL2_SLOW;
    logic filt_level;

    // Plain codes skip the window but still pass the filter's one-cycle register
    pin_debounce #(
        .CYCLES(DEBOUNCE_CYCLES)
    ) u_debounce (
        .clk(CORE_CLK),
        .srst(SRST),
        .level_in(pol_level),
        .long_en(long_fn),
        .level_out(filt_level)
    );

    // Pin sample and conditioned level history
    // Single sample stage; pins are already synchronous to the core clock
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            pin_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            pin_q <= PIN_IN;
            level_q <= filt_level;
        end
    end

    // Edges only count while the pin is an enabled input
    // edges of conditioned level
    wire rise = filt_level && !level_q;
    wire fall = !filt_level && level_q;
    wire edge_hit = in_active && (irq_edge_mode ? (rise || fall) : rise);

    // Sticky status: a new edge wins over a clear in the same cycle
    // Edges between two clears merge into one event
    assign irq_status_d = edge_hit
        || (irq_status_q && !(wr_clear && PWDATA[pin_nine_pkg::EDGE_EVENT_BIT]));

    // Status flop
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            irq_status_q <= 1'b0;
        end else begin
            irq_status_q <= irq_status_d;
        end
    end

    // Level interrupt; falls only on a clear or when software disables it
    assign IRQ = irq_status_q && irq_enable_q;

    wire [15:0] in_sel = in_active ? fn_onehot(pin_function_select) : 16'h0000;

    // Registered so downstream logic sees glitch-free request levels
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            in_func_q <= 16'h0000;
        end else begin
            in_func_q <= in_sel & {16{filt_level}};
        end
    end

    // Codes 0 and 1 are GPIO inputs seen only through the state register and the interrupt
    // Debounced and plain variants of one request share an output
    assign PWR_ONOFF_REQ = in_func_q[2];
    assign SLEEP_WAKE_REQ = in_func_q[3] | in_func_q[4];
    assign SLEEP_REQ = in_func_q[5];
    assign PWR_ON_REQ = in_func_q[6];
    assign WDOG_RESET_IN = in_func_q[7];
    assign VOLTAGE_SCALE_SELECT_ONE = in_func_q[8];
    assign VOLTAGE_SCALE_SELECT_TWO = in_func_q[9];
    assign HW_ENABLE_ONE = in_func_q[10];
    assign HW_ENABLE_TWO = in_func_q[11];
    assign HW_CONTROL_ONE = in_func_q[12] | in_func_q[14];
    assign HW_CONTROL_TWO = in_func_q[13] | in_func_q[15];

    // Bit n of the table is the source of output code n
    // output source table
    wire [15:0] out_src = {
        AUX_RESET, EXT_PWR_CLK, CONVERTER_POWER_OK, SYSTEM_SUPPLY_OK,
        EXT_PWR_EN_TWO, EXT_PWR_EN_ONE, SCALE_TWO_DONE, SCALE_ONE_DONE,
        3'b000, PWR_STATE_CHANGE, SLEEP_STATE, ON_STATE, SLOW_OSC_CLK, out_level_q
    };
    wire out_val = |(out_src & fn_onehot(pin_function_select));
    wire pin_val = out_val ^ ~pin_polarity;
    wire driving = pin_enable && !pin_direction;
    // Open drain never drives high; the pull or the far side sets that level
    // open drain releases high
    wire oe_n_d = !driving || (open_drain_select && pin_val);
    wire out_d = open_drain_select ? 1'b0 : pin_val;

    // Pin drive is registered; clock functions therefore lag by one cycle
    // Registering also keeps enable and level changing on the same edge
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            pin_out_q <= 1'b0;
            pin_oe_n_q <= 1'b1;
        end else begin
            pin_out_q <= out_d;
            pin_oe_n_q <= oe_n_d;
        end
    end

    assign PIN_OUT = pin_out_q;
    assign PIN_OE_N = pin_oe_n_q;
    // A reserved pull code never reaches here; the write keeps the old field
    // pull resistor controls
    assign PULL_UP_EN = pull_select == pin_nine_pkg::PULL_UP;
    assign PULL_DOWN_EN = pull_select == pin_nine_pkg::PULL_DOWN;
endmodule

// ---- testbench/pin_nine_ctrl_properties.sv ----
// Checker for pin nine control: control word mirror, pulls, pin drive, request timing.
// Assumes it is bound to pin_nine_ctrl and sees only its ports.
`timescale 1ns/10ps
module pin_nine_props (
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PIN_IN,
    input wire logic PIN_OUT,
    input wire logic PIN_OE_N,
    input wire logic PULL_UP_EN,
    input wire logic PULL_DOWN_EN,
    input wire logic PWR_ONOFF_REQ,
    input wire logic ON_STATE
);
    logic [15:0] ctl_q;
    logic [1:0] age_q;
    // Control accesses; a reserved pull code keeps the old pull
    wire acc = PSEL && PENABLE && PADDR == {16'h0, pin_nine_pkg::CTRL_ADDR};
    wire [1:0] pl = &PWDATA[14:13] ? ctl_q[14:13] : PWDATA[14:13];
    wire ok = age_q == 2'h3;
    wire drv = ok && ctl_q[7] && !ctl_q[15];
    wire in2 = ok && ctl_q[7] && ctl_q[15] && ctl_q[3:0] == 4'h2;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SRST);
    // Age holds checks off until registered outputs catch up with a write
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            ctl_q <= 16'ha400;
            age_q <= 2'h0;
        end else if (acc && PWRITE) begin
            ctl_q <= {PWDATA[15], pl, PWDATA[12:0]} & 16'hfe8f;
            age_q <= 2'h0;
        end else if (!ok) begin
            age_q <= age_q + 2'h1;
        end
    end
    chk_ctrl_read: assert property (acc && !PWRITE |-> PRDATA == {16'h0, ctl_q})
        else $error("control read differs");
    chk_pull_up: assert property (ok |-> PULL_UP_EN == (ctl_q[14:13] == 2'h2))
        else $error("pull-up enable wrong");
    chk_pull_down: assert property (ok |-> PULL_DOWN_EN == (ctl_q[14:13] == 2'h1))
        else $error("pull-down enable wrong");
    chk_tri_state: assert property (ok && !ctl_q[7] |-> PIN_OE_N)
        else $error("disabled pin driven");
    chk_cmos_drive: assert property (drv && !ctl_q[9] |-> !PIN_OE_N)
        else $error("push-pull pin released");
    chk_od_low: assert property (drv && ctl_q[9] |-> !PIN_OUT)
        else $error("open drain drives high");
    chk_state_src: assert property (drv && !ctl_q[9] && ctl_q[3:0] == 4'h2
        |-> PIN_OUT == ($past(ON_STATE) ^ !ctl_q[10])) else $error("state output wrong");
    chk_req_rise: assert property ((in2 && PIN_IN == ctl_q[10]) [*3] |=> PWR_ONOFF_REQ)
        else $error("request late");
    cover property (in2 && PWR_ONOFF_REQ);
    cover property (drv && ctl_q[9]);
    cover property (acc && PWRITE && &PWDATA[14:13]);
endmodule

// ---- testbench/pin_nine_far.sv ----
// Far-side logic of pin nine: resolves the wire from both drivers and the pulls.
// Assumes the bench says when the external logic drives.
`timescale 1ns/10ps
module pin_nine_far (
    input wire logic clk,
    input wire logic ext_en,
    input wire logic ext_lvl,
    input wire logic pin_out,
    input wire logic pin_oe_n,
    input wire logic pull_up,
    input wire logic pull_dn,
    output logic wire_lvl
);
    logic wander_q = 1'b0;
    // Floating wire changes every cycle, so no stale level is trusted
    always_ff @(posedge clk) begin
        wander_q <= !wander_q;
    end
    // Device drive, then ours, then pull
    assign wire_lvl = !pin_oe_n ? pin_out : ext_en ? ext_lvl :
        (pull_up || pull_dn) ? pull_up : wander_q;
endmodule

// ---- testbench/tb_multifunction_pin_nine_control.sv ----
// Bench for pin nine control with a model of the control word.
// Assumes the far-side model owns the wire; debounce cut to 4 cycles.
`timescale 1ns/10ps
module tb_multifunction_pin_nine_control;
    localparam int fn_bit[16] = '{-1, -1, 0, 1, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 9, 10};
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, ext_en = 1'b0, ext_lvl = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0;
    logic [15:0] src = 16'h0;
    logic [31:0] prdata, q, v;
    logic pready, pslverr, irq, pin_in, pin_out, oe_n, pu, pd, e, b;
    wire [10:0] fo;
    logic [15:0] m_ctl;
    int fail_count = 0;
    int tests_run = 0;
    // Clock at 250 MHz
    always #2 clk = !clk;
    pin_nine_ctrl #(.DEBOUNCE_CYCLES(4)) u_dut (.CORE_CLK(clk), .SRST(srst), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq), .PIN_IN(pin_in), .PIN_OUT(pin_out),
        .PIN_OE_N(oe_n), .PULL_UP_EN(pu), .PULL_DOWN_EN(pd), .PWR_ONOFF_REQ(fo[0]),
        .SLEEP_WAKE_REQ(fo[1]), .SLEEP_REQ(fo[2]), .PWR_ON_REQ(fo[3]), .WDOG_RESET_IN(fo[4]),
        .VOLTAGE_SCALE_SELECT_ONE(fo[5]), .VOLTAGE_SCALE_SELECT_TWO(fo[6]),
        .HW_ENABLE_ONE(fo[7]), .HW_ENABLE_TWO(fo[8]), .HW_CONTROL_ONE(fo[9]),
        .HW_CONTROL_TWO(fo[10]), .SLOW_OSC_CLK(src[1]), .ON_STATE(src[2]),
        .SLEEP_STATE(src[3]), .PWR_STATE_CHANGE(src[4]), .SCALE_ONE_DONE(src[8]),
        .SCALE_TWO_DONE(src[9]), .EXT_PWR_EN_ONE(src[10]), .EXT_PWR_EN_TWO(src[11]),
        .SYSTEM_SUPPLY_OK(src[12]), .CONVERTER_POWER_OK(src[13]), .EXT_PWR_CLK(src[14]),
        .AUX_RESET(src[15]));
    pin_nine_far u_far (.clk(clk), .ext_en(ext_en), .ext_lvl(ext_lvl), .pin_out(pin_out),
        .pin_oe_n(oe_n), .pull_up(pu), .pull_dn(pd), .wire_lvl(pin_in));
    // One APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= {16'h0, a};
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    // Control write; the model keeps the old pull on the reserved code
    task automatic setc(input logic [15:0] c);
        apb(1'b1, pin_nine_pkg::CTRL_ADDR, {16'h0, c});
        if (&c[14:13]) begin
            c[14:13] = m_ctl[14:13];
        end
        m_ctl = c & 16'hfe8f;
    endtask
    task automatic chk(input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            fail_count++;
            $display("FAIL t=%0t exp=%h got=%h", $time, x, g);
        end
    endtask
    task automatic stop_test();
        if (fail_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        stop_test();
    end
    initial begin
        void'($urandom(32'hfac78a1f));
        m_ctl = 16'ha400;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        // Reset image, then written words, the first all ones with the reserved pull, the rest random
        for (int i = 0; i < 9; i++) begin
            v = (i == 1) ? 32'hffffffff : $urandom();
            if (i > 0) begin
                setc(v[15:0]);
            end
            apb(1'b0, pin_nine_pkg::CTRL_ADDR, 32'h0);
            chk({16'h0, m_ctl}, q);
        end
        apb(1'b0, 16'h4044, 32'h0);
        chk(32'h1, {q[31:1], e});
        // Every input code, debounced codes included
        ext_en <= 1'b1;
        for (int f = 0; f < 16; f++) begin
            setc(16'ha480 | 16'(f));
            ext_lvl <= 1'b1;
            repeat (16) @(posedge clk);
            chk(fn_bit[f] < 0 ? 32'h0 : 32'h1 << fn_bit[f], {21'h0, fo});
            apb(1'b0, pin_nine_pkg::PIN_STATE_ADDR, 32'h0);
            chk(32'h1, {31'h0, q[0]});
            ext_lvl <= 1'b0;
            repeat (16) @(posedge clk);
            chk(32'h0, {21'h0, fo});
        end
        // Short pulse must not pass the long debounce
        setc(16'ha484);
        ext_lvl <= 1'b1;
        repeat (2) @(posedge clk);
        ext_lvl <= 1'b0;
        repeat (2) @(posedge clk);
        chk(32'h0, {21'h0, fo});
        repeat (14) @(posedge clk);
        chk(32'h0, {21'h0, fo});
        // Edge modes under both polarities
        apb(1'b1, pin_nine_pkg::IRQ_ENABLE_ADDR, 32'h1);
        for (int k = 0; k < 4; k++) begin
            setc(16'ha081 | {3'h0, k[1], 1'b0, k[0], 10'h0});
            ext_lvl <= !k[0];
            repeat (16) @(posedge clk);
            apb(1'b1, pin_nine_pkg::IRQ_CLEAR_ADDR, 32'h1);
            chk(32'h0, {31'h0, irq});
            ext_lvl <= k[0];
            repeat (16) @(posedge clk);
            chk(32'h1, {31'h0, irq});
            apb(1'b1, pin_nine_pkg::IRQ_CLEAR_ADDR, 32'h1);
            ext_lvl <= !k[0];
            repeat (16) @(posedge clk);
            chk({31'h0, k[1]}, {31'h0, irq});
        end
        apb(1'b1, pin_nine_pkg::IRQ_ENABLE_ADDR, 32'h0);
        chk(32'h0, {31'h0, irq});
        apb(1'b0, pin_nine_pkg::IRQ_STATUS_ADDR, 32'h0);
        chk(32'h1, q);
        // Every output code with random sources and polarity, push-pull then open drain
        ext_en <= 1'b0;
        for (int f = 0; f < 32; f++) begin
            v = $urandom();
            v[9] = f[4];
            src <= v[31:16];
            apb(1'b1, pin_nine_pkg::OUT_LEVEL_ADDR, {31'h0, v[0]});
            apb(1'b0, pin_nine_pkg::OUT_LEVEL_ADDR, 32'h0);
            chk({31'h0, v[0]}, q);
            setc((v[15:0] & 16'h0600) | 16'h2080 | {12'h0, f[3:0]});
            repeat (4) @(posedge clk);
            b = ((f[3:0] >= 4'h5 && f[3:0] <= 4'h7) ? 1'b0
                : (f[3:0] == 4'h0) ? v[0] : v[16 + f[3:0]]) ^ !v[10];
            chk(v[9] ? {30'h0, b, 1'b0} : {31'h0, b}, {30'h0, oe_n, pin_out});
            chk(32'h0, {21'h0, fo});
        end
        // Disabled pin stays released and silent
        setc(16'ha402);
        ext_en <= 1'b1;
        ext_lvl <= 1'b1;
        repeat (16) @(posedge clk);
        chk(32'h1, {21'h0, fo, oe_n});
        stop_test();
    end
endmodule
bind pin_nine_ctrl pin_nine_props u_props (.CORE_CLK, .SRST, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PWDATA, .PRDATA, .PIN_IN, .PIN_OUT, .PIN_OE_N, .PULL_UP_EN, .PULL_DOWN_EN,
    .PWR_ONOFF_REQ, .ON_STATE);
